// ---- src/telm_pkg.sv ----
// Constants and types shared by the touch event light mapper
// Operation
// - Group 1 enables: bit 6 wheel touch, 5 clockwise, 4 counter-clockwise, rest buttons.
// - A group event is raised whenever any of its enabled sensor events occurs.
// - Every group 1 enable bit is set independently; any combination works.
// - Segment change needs position hysteresis, percent of wheel maximum, reset code 0x02.
// - The one hysteresis value applies to every segment boundary.
// - Wake-up sequence length takes 1 to 5 successive button touches.
// - Length 0 wakes on any sensor event.
// - Length 6 ignores sensor events; only input pin or host command wakes.
// - Each key pair register: earlier key lower nibble, next key upper nibble.
// - Each auto-lit pin follows the one event or group selected for it.
// - A pin mapped to a group is driven by any enabled event of it.
// - Button or wheel touch pins turn on at touch, off at release.
// - Clockwise pins turn on at clockwise, off at counter-clockwise or release.
// - Counter-clockwise pins turn on at counter-clockwise, off at clockwise or release.
// - Selector values equal to a button index select that button.
// - Selector value 0x0C selects event group 0.
// - Wheel splits into as many equal segments as pins mapped to segments.
// - Lowest pin takes lowest segment; on while its segment touched, off on release.
// - Selector 0x0E selects counter-clockwise rotation, 0x0F clockwise rotation.
package telm_pkg;
   localparam int        NUM_PINS      = 8;
   localparam int        NUM_BTNS      = 12;
   localparam int        POS_W         = 8;
   localparam int        SEL_REGS      = 4;
   localparam int        WK_PAIRS      = 3;
   // Register offsets
   localparam logic [7:0] ADDR_WK_LEN   = 8'h33;
   localparam logic [7:0] ADDR_WK_KEY0  = 8'h34;
   localparam logic [7:0] ADDR_WK_KEY2  = 8'h36;
   localparam logic [7:0] ADDR_SEL_FIRST = 8'h37;
   localparam logic [7:0] ADDR_SEL_LAST = 8'h3a;
   localparam logic [7:0] ADDR_GRP0_HI  = 8'h3b;
   localparam logic [7:0] ADDR_GRP0_LO  = 8'h3c;
   localparam logic [7:0] ADDR_GRP1_HI  = 8'h3d;
   localparam logic [7:0] ADDR_GRP1_LO  = 8'h3e;
   localparam logic [7:0] ADDR_HYST     = 8'h3f;
   // Reset values and masks
   localparam logic [7:0] HYST_RESET    = 8'h02;
   localparam logic [7:0] CFG_RESET     = 8'h00;
   localparam logic [7:0] GRP_HI_MASK   = 8'h7f;
   localparam logic [7:0] NOT_MAPPED    = 8'h00;
   // Enable pair bit positions, {high, low}
   localparam int        EN_WHEEL_BIT  = 14;
   localparam int        EN_SEG_BIT    = 14;
   localparam int        EN_CW_BIT     = 13;
   localparam int        EN_CCW_BIT    = 12;
   // Selector codes
   localparam logic [3:0] SEL_GROUP0    = 4'hc;
   localparam logic [3:0] SEL_GROUP1    = 4'hd;
   localparam logic [3:0] SEL_CCW       = 4'he;
   localparam logic [3:0] SEL_CW        = 4'hf;
   // Wheel and hysteresis
   localparam logic [15:0] WHEEL_POS_MAX = 16'h00ff;
   localparam logic [11:0] POS_SPAN     = 12'h100;
   localparam logic [7:0] HYST_FULL     = 8'h64;
   // Wake-up lengths
   localparam logic [7:0] WK_LEN_ANY    = 8'h00;
   localparam logic [7:0] WK_LEN_EXT    = 8'h06;
   typedef enum logic {WK_IDLE, WK_TRACK} telm_wk_t;
endpackage

// ---- src/telm_regs.sv ----
// Configuration register file of the mapper
`timescale 1ns/10ps
module telm_regs
   import telm_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic                      rstn,
   input  wire logic                      regWrEn,
   input  wire logic                      regRdEn,
   input  wire logic [7:0]                regAddr,
   input  wire logic [7:0]                regWrData,
   output      logic [7:0]                regRdData,
   output      logic [NUM_PINS-1:0][3:0]  pinSel,
   output      logic [15:0]               grp0En,
   output      logic [15:0]               grp1En,
   output      logic [7:0]                hystCode,
   output      logic [7:0]                wkLen,
   output      logic [WK_PAIRS-1:0][7:0]  wkPairs
);
   typedef struct packed {
      logic [SEL_REGS-1:0][7:0] sel;
      logic [15:0]              g0;
      logic [15:0]              g1;
      logic [7:0]               hyst;
      logic [7:0]               len;
      logic [WK_PAIRS-1:0][7:0] wk;
      logic [7:0]               rd;
   } telm_regs_st_t;

   telm_regs_st_t st_r;
   telm_regs_st_t st_nxt;

   // ==========================================
   // Decode
   always_comb begin
      st_nxt = st_r;
      if (regWrEn) begin
         if (regAddr >= ADDR_SEL_FIRST && regAddr <= ADDR_SEL_LAST) begin
            st_nxt.sel[2'(ADDR_SEL_LAST - regAddr)] = regWrData;
         end else if (regAddr == ADDR_GRP0_HI) begin
            st_nxt.g0[15:8] = regWrData & GRP_HI_MASK;
         end else if (regAddr == ADDR_GRP0_LO) begin
            st_nxt.g0[7:0] = regWrData;
         end else if (regAddr == ADDR_GRP1_HI) begin
            st_nxt.g1[15:8] = regWrData & GRP_HI_MASK;
         end else if (regAddr == ADDR_GRP1_LO) begin
            st_nxt.g1[7:0] = regWrData;
         end else if (regAddr == ADDR_HYST) begin
            st_nxt.hyst = regWrData;
         end else if (regAddr == ADDR_WK_LEN) begin
            st_nxt.len = regWrData;
         end else if (regAddr >= ADDR_WK_KEY0 && regAddr <= ADDR_WK_KEY2) begin
            st_nxt.wk[2'(regAddr - ADDR_WK_KEY0)] = regWrData;
         end
      end
      if (regRdEn) begin
         if (regAddr >= ADDR_SEL_FIRST && regAddr <= ADDR_SEL_LAST) begin
            st_nxt.rd = st_r.sel[2'(ADDR_SEL_LAST - regAddr)];
         end else if (regAddr == ADDR_GRP0_HI) begin
            st_nxt.rd = st_r.g0[15:8];
         end else if (regAddr == ADDR_GRP0_LO) begin
            st_nxt.rd = st_r.g0[7:0];
         end else if (regAddr == ADDR_GRP1_HI) begin
            st_nxt.rd = st_r.g1[15:8];
         end else if (regAddr == ADDR_GRP1_LO) begin
            st_nxt.rd = st_r.g1[7:0];
         end else if (regAddr == ADDR_HYST) begin
            st_nxt.rd = st_r.hyst;
         end else if (regAddr == ADDR_WK_LEN) begin
            st_nxt.rd = st_r.len;
         end else if (regAddr >= ADDR_WK_KEY0 && regAddr <= ADDR_WK_KEY2) begin
            st_nxt.rd = st_r.wk[2'(regAddr - ADDR_WK_KEY0)];
         end else begin
            st_nxt.rd = NOT_MAPPED;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r      <= '0;
         st_r.hyst <= HYST_RESET;
         st_r.len  <= CFG_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Selector bytes run from pins 7:6 at 0x37 down to pins 1:0 at 0x3a, odd pin in the upper nibble
   assign pinSel    = st_r.sel;
   assign grp0En    = st_r.g0;
   assign grp1En    = st_r.g1;
   assign hystCode  = st_r.hyst;
   assign wkLen     = st_r.len;
   assign wkPairs   = st_r.wk;
   assign regRdData = st_r.rd;
endmodule

// ---- src/telm_segment.sv ----
// Wheel segment tracker with position hysteresis
`timescale 1ns/10ps
module telm_segment
   import telm_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              scanValid,
   input  wire logic              wheelTouch,
   input  wire logic [POS_W-1:0]  wheelPos,
   input  wire logic [3:0]        segCount,
   input  wire logic [7:0]        hystCode,
   output      logic [2:0]        segIdx,
   output      logic              segActive
);
   typedef struct packed {
      logic [2:0] seg;
      logic       active;
   } telm_seg_st_t;

   telm_seg_st_t st_r;
   telm_seg_st_t st_nxt;

   function automatic logic [10:0] segBound(input logic [3:0] k, input logic [3:0] n);
      logic [11:0] prod;
      prod = 12'(k) * POS_SPAN;
      segBound = (n == 4'h0) ? 11'h000 : 11'(prod / 12'(n));
   endfunction

   logic [2:0]  cand;
   logic [10:0] hyst;
   logic [10:0] pos;
   logic [7:0]  hClamp;

   // ==========================================
   // Segment choice
   always_comb begin
      pos    = 11'(wheelPos);
      hClamp = (hystCode > HYST_FULL) ? HYST_FULL : hystCode;
      hyst   = 11'((16'(hClamp) * WHEEL_POS_MAX) / 16'(HYST_FULL));
      cand   = 3'h0;
      for (int k = 1; k < NUM_PINS; k++) begin
         if (4'(k) < segCount && pos >= segBound(4'(k), segCount)) begin
            cand = 3'(k);
         end
      end
      st_nxt = st_r;
      if (scanValid) begin
         if (!wheelTouch || segCount == 4'h0) begin
            st_nxt.active = 1'b0;
         end else if (!st_r.active || 4'(st_r.seg) >= segCount) begin
            st_nxt.active = 1'b1;
            st_nxt.seg    = cand;
         end else if (cand > st_r.seg) begin
            // Same margin on every boundary keeps a finger on a seam from flicking
            if (pos >= segBound(4'(st_r.seg) + 4'h1, segCount) + hyst) begin
               st_nxt.seg = cand;
            end
         end else if (cand < st_r.seg) begin
            if (pos + hyst < segBound(4'(st_r.seg), segCount)) begin
               st_nxt.seg = cand;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign segIdx    = st_r.seg;
   assign segActive = st_r.active;
endmodule

// ---- src/telm_top.sv ----
// Touch event to auto-light pin mapper and wake-up sequence matcher
`timescale 1ns/10ps
module telm_top
   import telm_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   input  wire logic                 regWrEn,
   input  wire logic                 regRdEn,
   input  wire logic [7:0]           regAddr,
   input  wire logic [7:0]           regWrData,
   output      logic [7:0]           regRdData,
   input  wire logic                 scanValid,
   input  wire logic [NUM_BTNS-1:0]  btnTouch,
   input  wire logic                 wheelTouch,
   input  wire logic                 rotCw,
   input  wire logic                 rotCcw,
   input  wire logic [POS_W-1:0]     wheelPos,
   input  wire logic                 gpiWake,
   input  wire logic                 hostWakeCmd,
   output      logic [NUM_PINS-1:0]  lightOn,
   output      logic                 wakeUp
);
   typedef struct packed {
      logic [NUM_BTNS-1:0] btn;
      logic                wheel;
      logic                cw;
      logic                ccw;
      logic [NUM_PINS-1:0] light;
      telm_wk_t            wk;
      logic [2:0]          wkIdx;
      logic                wake;
   } telm_top_st_t;

   telm_top_st_t st_r;
   telm_top_st_t st_nxt;

   logic [NUM_PINS-1:0][3:0] pinSel;
   logic [15:0]              grp0En;
   logic [15:0]              grp1En;
   logic [7:0]               hystCode;
   logic [7:0]               wkLen;
   logic [WK_PAIRS-1:0][7:0] wkPairs;
   logic [2:0]               segIdx;
   logic                     segActive;

   // ==========================================
   // Helpers
   function automatic logic [3:0] countOnes(input logic [NUM_PINS-1:0] v);
      countOnes = 4'h0;
      for (int i = 0; i < NUM_PINS; i++) begin
         countOnes = countOnes + 4'(v[i]);
      end
   endfunction

   function automatic logic [3:0] keyAt(input logic [WK_PAIRS-1:0][7:0] pr,
                                        input logic [2:0] i);
      logic [7:0] b;
      b     = pr[2'(i >> 1)];
      keyAt = i[0] ? b[7:4] : b[3:0];
   endfunction

   function automatic logic [3:0] lowestPress(input logic [NUM_BTNS-1:0] v);
      lowestPress = 4'h0;
      for (int i = NUM_BTNS - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowestPress = 4'(i);
         end
      end
   endfunction

   // ==========================================
   // Submodules
   telm_regs u_regs (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .regWrEn   (regWrEn),
      .regRdEn   (regRdEn),
      .regAddr   (regAddr),
      .regWrData (regWrData),
      .regRdData (regRdData),
      .pinSel    (pinSel),
      .grp0En    (grp0En),
      .grp1En    (grp1En),
      .hystCode  (hystCode),
      .wkLen     (wkLen),
      .wkPairs   (wkPairs)
   );

   logic [NUM_PINS-1:0] segPin;
   logic [3:0]          segCount;
   logic                segMode;

   telm_segment u_seg (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .scanValid  (scanValid),
      .wheelTouch (wheelTouch),
      .wheelPos   (wheelPos),
      .segCount   (segCount),
      .hystCode   (hystCode),
      .segIdx     (segIdx),
      .segActive  (segActive)
   );

   // ==========================================
   // Event groups
   logic [15:0]         ev0;
   logic [15:0]         ev1;
   logic                grp0Hit;
   logic                grp1Hit;
   logic [NUM_BTNS-1:0] newPress;
   logic                anyEvent;
   logic [3:0]          pressKey;

   always_comb begin
      ev0 = '0;
      ev0[NUM_BTNS-1:0] = st_r.btn;
      ev0[EN_CW_BIT]    = st_r.cw;
      ev0[EN_CCW_BIT]   = st_r.ccw;
      ev1 = ev0;
      ev1[EN_WHEEL_BIT] = st_r.wheel;
      // Segment bit is not a level event, so it never feeds the group OR
      grp0Hit = |(ev0 & grp0En);
      grp1Hit = |(ev1 & grp1En);
      // Segment mode only when the segment bit is alone in group 0
      segMode = grp0En[EN_SEG_BIT] &&
                ((grp0En & ~(16'h0001 << EN_SEG_BIT)) == 16'h0000);
      for (int p = 0; p < NUM_PINS; p++) begin
         segPin[p] = segMode && (pinSel[p] == SEL_GROUP0);
      end
      segCount = countOnes(segPin);
      newPress = btnTouch & ~st_r.btn;
      anyEvent = scanValid && ((|newPress) || (wheelTouch && !st_r.wheel) || rotCw || rotCcw);
      pressKey = lowestPress(newPress);
   end

   // ==========================================
   // Next state
   always_comb begin
      st_nxt      = st_r;
      st_nxt.wake = 1'b0;
      if (scanValid) begin
         st_nxt.btn   = btnTouch;
         st_nxt.wheel = wheelTouch;
         if (!wheelTouch) begin
            st_nxt.cw  = 1'b0;
            st_nxt.ccw = 1'b0;
         end else if (rotCw) begin
            st_nxt.cw  = 1'b1;
            st_nxt.ccw = 1'b0;
         end else if (rotCcw) begin
            st_nxt.ccw = 1'b1;
            st_nxt.cw  = 1'b0;
         end
      end
      // Lights follow the registered scan state, one cycle behind it
      for (int p = 0; p < NUM_PINS; p++) begin
         if (pinSel[p] < SEL_GROUP0) begin
            st_nxt.light[p] = st_r.btn[pinSel[p]];
         end else if (pinSel[p] == SEL_GROUP0) begin
            if (segPin[p]) begin
               st_nxt.light[p] = segActive &&
                  (4'(segIdx) == countOnes(segPin & ((8'h01 << p) - 8'h01)));
            end else begin
               st_nxt.light[p] = grp0Hit;
            end
         end else if (pinSel[p] == SEL_GROUP1) begin
            st_nxt.light[p] = grp1Hit;
         end else if (pinSel[p] == SEL_CCW) begin
            st_nxt.light[p] = st_r.ccw;
         end else begin
            st_nxt.light[p] = st_r.cw;
         end
      end
      // Wake-up matching
      if (gpiWake || hostWakeCmd) begin
         st_nxt.wake = 1'b1;
      end
      if (wkLen == WK_LEN_ANY) begin
         st_nxt.wk    = WK_IDLE;
         st_nxt.wkIdx = 3'h0;
         if (anyEvent) begin
            st_nxt.wake = 1'b1;
         end
      end else if (wkLen >= WK_LEN_EXT) begin
         st_nxt.wk    = WK_IDLE;
         st_nxt.wkIdx = 3'h0;
      end else if (scanValid && (|newPress)) begin
         case (st_r.wk)
            WK_IDLE: begin
               if (pressKey == keyAt(wkPairs, 3'h0)) begin
                  if (wkLen == 8'(1)) begin
                     st_nxt.wake = 1'b1;
                  end else begin
                     st_nxt.wk    = WK_TRACK;
                     st_nxt.wkIdx = 3'h1;
                  end
               end
            end
            WK_TRACK: begin
               if (pressKey == keyAt(wkPairs, st_r.wkIdx)) begin
                  if (8'(st_r.wkIdx) + 8'(1) == wkLen) begin
                     st_nxt.wake  = 1'b1;
                     st_nxt.wk    = WK_IDLE;
                     st_nxt.wkIdx = 3'h0;
                  end else begin
                     st_nxt.wkIdx = st_r.wkIdx + 3'h1;
                  end
               end else begin
                  // A wrong key restarts; keeps the matcher simple and strict
                  st_nxt.wk    = WK_IDLE;
                  st_nxt.wkIdx = 3'h0;
               end
            end
            default: begin
               st_nxt.wk = WK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lightOn = st_r.light;
   assign wakeUp  = st_r.wake;

   // ==========================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence sBtnTouch;
      scanValid && pinSel[0] < SEL_GROUP0 && btnTouch[pinSel[0]];
   endsequence

   sequence sCwTurn;
      scanValid && wheelTouch && rotCw && pinSel[0] == SEL_CW;
   endsequence

   sequence sCcwTurn;
      scanValid && wheelTouch && rotCcw && !rotCw && pinSel[0] == SEL_CCW;
   endsequence

   sequence sHold;
      $stable(pinSel[0]) && !scanValid;
   endsequence

   a_btn_light_on: assert property (sBtnTouch ##1 sHold |=> lightOn[0])
      else $error("button pin did not light");
   a_cw_light_on: assert property (sCwTurn ##1 sHold |=> lightOn[0])
      else $error("clockwise pin did not light");
   a_ccw_light_on: assert property (sCcwTurn ##1 sHold |=> lightOn[0])
      else $error("counter-clockwise pin did not light");
   a_release_turn_off: assert property (
      scanValid && !wheelTouch && (pinSel[0] == SEL_CW || pinSel[0] == SEL_CCW)
      ##1 sHold |=> !lightOn[0])
      else $error("rotation pin stayed on after release");
   a_group1_or: assert property (
      (pinSel[1] == SEL_GROUP1 && |(ev1 & grp1En)) |=> lightOn[1])
      else $error("group 1 pin missed an enabled event");
   a_group0_select: assert property (
      (pinSel[2] == SEL_GROUP0 && !segMode && !grp0Hit) |=> !lightOn[2])
      else $error("group 0 pin lit with no enabled event");
   a_wake_any: assert property (
      (wkLen == WK_LEN_ANY && anyEvent) |=> wakeUp)
      else $error("no wake on sensor event at length zero");
   a_wake_ext_only: assert property (
      (wkLen == WK_LEN_EXT && !gpiWake && !hostWakeCmd) |=> !wakeUp)
      else $error("sensor event woke device at length six");
   a_seg_range: assert property (
      (segActive && $stable(segCount) && segCount != 4'h0 && !scanValid)
      |-> 4'(segIdx) < segCount)
      else $error("segment index outside mapped count");
endmodule

// ---- testbench/telm_bench.sv ----
// Self-checking bench of the touch event light mapper
`timescale 1ns/10ps
module telm_bench
   import telm_pkg::*;
;
   logic                ref_clk, rstn, regWrEn, regRdEn, gpiWake, hostWakeCmd, wakeUp;
   logic [7:0]          regAddr, regWrData, regRdData;
   logic                scanValid, wheelTouch, rotCw, rotCcw, w, cwSt, ccwSt;
   logic [NUM_BTNS-1:0] btnTouch;
   logic [POS_W-1:0]    wheelPos;
   logic [NUM_PINS-1:0] lightOn;
   logic [14:0]         g0, g1, ev;
   logic [3:0]          r;
   int                  fails, num_checks, wakes, w0;
   int                  sel [NUM_PINS];
   logic [7:0]          segPos [8] = '{8'h0a, 8'h00, 8'hc8, 8'h7d, 8'h64, 8'h82, 8'h8c, 8'h00};
   logic [7:0]          segExp [8] = '{8'h01, 8'h00, 8'h02, 8'h02, 8'h01, 8'h01, 8'h02, 8'h00};

   telm_top dut_u (.ref_clk, .rstn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
      .scanValid, .btnTouch, .wheelTouch, .rotCw, .rotCcw, .wheelPos, .gpiWake,
      .hostWakeCmd, .lightOn, .wakeUp);
   telm_scan_model scan_u (.ref_clk, .scanValid, .btnTouch, .wheelTouch, .rotCw, .rotCcw,
      .wheelPos);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Wake is a one-cycle pulse, so count it on every rising edge
   always @(posedge ref_clk) if (wakeUp === 1'b1) wakes <= wakes + 1;

   // ==========
   // Tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      {regWrEn, regAddr, regWrData} = {1'b1, a, d};
      @(negedge ref_clk);
      regWrEn = 1'b0;
      if (a >= 8'h37 && a <= 8'h3a) begin
         sel[2 * (8'h3a - a)] = d[3:0];
         sel[2 * (8'h3a - a) + 1] = d[7:4];
      end
      if (a == ADDR_GRP0_HI) g0[14:8] = d[6:0];
      if (a == ADDR_GRP0_LO) g0[7:0] = d;
      if (a == ADDR_GRP1_HI) g1[14:8] = d[6:0];
      if (a == ADDR_GRP1_LO) g1[7:0] = d;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      {regRdEn, regAddr} = {1'b1, a};
      @(negedge ref_clk);
      regRdEn = 1'b0;
      chk(regRdData, exp);
   endtask
   task automatic sc(input logic [11:0] b, input logic t, c, cc, input logic [7:0] p);
      scan_u.scan(b, t, c, cc, p);
      if (!t) {cwSt, ccwSt} = 2'b00;
      else if (c) {cwSt, ccwSt} = 2'b10;
      else if (cc) {cwSt, ccwSt} = 2'b01;
      ev = {t, cwSt, ccwSt, b};
      repeat (2) @(negedge ref_clk);
   endtask
   function automatic logic [7:0] expLight();
      logic [7:0] e;
      for (int p = 0; p < NUM_PINS; p++) begin
         case (sel[p])
            12: e[p] = |(ev & g0);
            13: e[p] = |(ev & g1);
            14: e[p] = ccwSt;
            15: e[p] = cwSt;
            default: e[p] = ev[sel[p]];
         endcase
      end
      return e;
   endfunction
   task automatic wk(input logic [11:0] a, input logic [11:0] b, input logic [7:0] exp);
      w0 = wakes;
      sc(a, 1'b0, 1'b0, 1'b0, 8'h00);
      sc(12'h000, 1'b0, 1'b0, 1'b0, 8'h00);
      sc(b, 1'b0, 1'b0, 1'b0, 8'h00);
      sc(12'h000, 1'b0, 1'b0, 1'b0, 8'h00);
      chk(8'(wakes - w0), exp);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      close_out();
   end

   // ==========
   // Sequence
   initial begin
      {rstn, regWrEn, regRdEn, regAddr, regWrData, gpiWake, hostWakeCmd} = '0;
      {fails, num_checks, wakes, g0, g1, cwSt, ccwSt, ev} = '0;
      sel = '{default: 0};
      void'($urandom(66));
      repeat (5) @(negedge ref_clk);
      chk(lightOn, 8'h00);
      chk({7'h00, wakeUp}, 8'h00);
      rstn = 1'b1;
      rdc(ADDR_HYST, 8'h02);
      rdc(ADDR_GRP1_HI, 8'h00);
      wr(ADDR_GRP1_HI, 8'hff);
      rdc(ADDR_GRP1_HI, 8'h7f);
      wr(ADDR_HYST, 8'h64);
      rdc(ADDR_HYST, 8'h64);
      wr(8'h20, 8'h5a);
      rdc(8'h20, 8'h00);
      r = 4'($urandom_range(11));
      wr(8'h3a, {4'hd, r});
      wr(8'h39, 8'hec);
      wr(8'h38, {r + 4'h1, 4'hf});
      wr(8'h37, 8'hb0);
      wr(ADDR_GRP0_HI, 8'h30);
      wr(ADDR_GRP0_LO, 8'h03);
      wr(ADDR_GRP1_HI, 8'h48);
      wr(ADDR_GRP1_LO, 8'($urandom));
      repeat (30) begin
         w = 1'($urandom);
         sc(12'($urandom), w, w & 1'($urandom), w & 1'($urandom), 8'($urandom));
         chk(lightOn, expLight());
      end
      // Pin 0 on each rotation select: turn first, then release
      for (int i = 0; i < 4; i++) begin
         wr(8'h3a, {4'hd, (i < 2) ? SEL_CW : SEL_CCW});
         sc(12'($urandom), !i[0], i == 0, i == 2, 8'($urandom));
         chk(lightOn, expLight());
      end
      // Segment mode needs the segment bit alone in group 0
      wr(ADDR_GRP0_HI, 8'h40);
      wr(ADDR_GRP0_LO, 8'h00);
      wr(8'h3a, 8'hcc);
      for (int a = 8'h37; a < 8'h3a; a++) wr(8'(a), 8'h00);
      wr(ADDR_HYST, 8'h02);
      for (int i = 0; i < 8; i++) begin
         sc(12'h000, segPos[i] != 8'h00, 1'b0, 1'b0, segPos[i]);
         chk(lightOn, segExp[i]);
      end
      wr(ADDR_WK_LEN, 8'h00);
      wk(12'h008, 12'h002, 8'h02);
      wr(ADDR_WK_LEN, 8'h02);
      wr(ADDR_WK_KEY0, 8'h52);
      wk(12'h004, 12'h020, 8'h01);
      wk(12'h020, 12'h004, 8'h00);
      wr(ADDR_WK_LEN, 8'h06);
      wk(12'h004, 12'h020, 8'h00);
      w0 = wakes;
      @(negedge ref_clk) gpiWake = 1'b1;
      @(negedge ref_clk) gpiWake = 1'b0;
      hostWakeCmd = 1'b1;
      @(negedge ref_clk) hostWakeCmd = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(8'(wakes - w0), 8'h02);
      close_out();
   end
endmodule

// ---- testbench/telm_scan_model.sv ----
// Scan engine model feeding sensor results to the mapper
`timescale 1ns/10ps
module telm_scan_model
   import telm_pkg::*;
(
   input  wire logic                ref_clk,
   output      logic                scanValid,
   output      logic [NUM_BTNS-1:0] btnTouch,
   output      logic                wheelTouch,
   output      logic                rotCw,
   output      logic                rotCcw,
   output      logic [POS_W-1:0]    wheelPos
);
   // ==========
   // Between scans the lines wander, so stale values cannot leak in
   task automatic noise();
      {btnTouch, wheelTouch, rotCw, rotCcw, wheelPos} = 23'($urandom);
   endtask
   initial begin
      scanValid = 1'b0;
      noise();
   end
   // One result per pulse, launched on the falling edge
   task automatic scan(input logic [11:0] b, input logic w, c, cc, input logic [7:0] p);
      @(negedge ref_clk);
      scanValid = 1'b1;
      {btnTouch, wheelTouch, rotCw, rotCcw, wheelPos} = {b, w, c, cc, p};
      @(negedge ref_clk);
      scanValid = 1'b0;
      noise();
   endtask
endmodule
